//--- pcie_region_window_regs.svh
/*
  Offsets, field positions, masks and reset values of the region window bank.
  Definitions only; included by the package and by the bank itself.
*/
// Notes on behaviour
// RULE1 - Start registers keep address bits 47:20 in field 28:1, read-write.
// RULE2 - End registers keep address bits 47:20 in field 27:0, read-write.
// RULE3 - Start bit 0 enables the region; disabled regions never match.
// RULE4 - Start bit 29 set makes the region non-secure, every transaction passes.
// RULE5 - Start bit 29 clear makes the region secure, only secure transactions pass.
// RULE6 - Unused upper bits read zero and ignore writes.
// RULE7 - Fine control field 9:5 holds second window start bits 19:15.
// RULE8 - Fine control field 4:0 holds second window end bits 19:15.
// RULE9 - Every register of the bank is always present.
// RULE10 - The x16 side has its own first config window start/end pair.
// RULE11 - The x8 side has a second config window pair plus fine control.
// RULE12 - The x16 side has a low I/O window start/end pair.
// RULE13 - After reset all writable fields are zero: regions off and secure.
// RULE14 - An address hits an enabled region when start <= address <= end.
`ifndef PCIE_REGION_WINDOW_REGS_SVH
`define PCIE_REGION_WINDOW_REGS_SVH
`define APB_ADDR_W 12
`define NUM_REGS 8
`define OFS_X8_CFG_LAST 12'h224
`define OFS_X8_SEC_START 12'h228
`define OFS_X8_SEC_LAST 12'h22C
`define OFS_X8_SEC_FINE 12'h230
`define OFS_X16_FST_START 12'h300
`define OFS_X16_FST_LAST 12'h304
`define OFS_X16_LIO_START 12'h308
`define OFS_X16_LIO_LAST 12'h30C
`define START_EN_BIT 0
`define START_LSB 1
`define START_MSB 28
`define NONSEC_BIT 29
`define LAST_MSB 27
`define FINE_LAST_MSB 4
`define FINE_START_LSB 5
`define FINE_START_MSB 9
`define START_MASK 32'h3FFF_FFFF
`define LAST_MASK 32'h0FFF_FFFF
`define FINE_MASK 32'h0000_03FF
`define REG_RESET 32'h0000_0000
`define FINE_LAST_FULL 5'h1F
`define FINE_START_ZERO 5'h00
`endif

//--- pcie_region_window_pkg.sv
/*
  Types shared by the region window bank and its window matcher.
  Assumes the constants header is on the include path.
*/
`include "pcie_region_window_regs.svh"
package pcie_region_window_pkg;
  // One address window as the decoder sees it
  typedef struct packed {
    logic en;
    logic nonsecure;
    logic [`START_MSB-`START_LSB:0] start;
    logic [`LAST_MSB:0] last;
  } region_cfg_s;
  // Sub-megabyte refinement of a window
  typedef struct packed {
    logic [`FINE_START_MSB-`FINE_START_LSB:0] start;
    logic [`FINE_LAST_MSB:0] last;
  } fine_cfg_s;
endpackage

//--- region_window_match.sv
/*
  Compares one lookup address with one programmed window.
  Assumes the window settings come from flops and the lookup is synchronous to clk.
*/
`timescale 1ns/100ps
module region_window_match #(
  parameter int ADDR_W = 48
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Window settings
  input pcie_region_window_pkg::region_cfg_s cfg,
  input pcie_region_window_pkg::fine_cfg_s fine,
  // Lookup
  input wire logic [ADDR_W-1:0] lookup_addr,
  input wire logic lookup_secure,
  output logic hit,
  output logic allow
);
  localparam int CMP_W = $bits(cfg.last) + $bits(fine.last);
  logic [CMP_W-1:0] lo_bound;
  logic [CMP_W-1:0] hi_bound;
  logic [CMP_W-1:0] probe;
  logic hit_d;
  logic allow_d;
  logic hit_q;
  logic allow_q;

  // Bounds are inclusive; the end bound already names the last granule
  assign lo_bound = {cfg.start, fine.start};
  assign hi_bound = {cfg.last, fine.last};
  assign probe = lookup_addr[ADDR_W-1 -: CMP_W];
  assign hit_d = cfg.en && (probe >= lo_bound) && (probe <= hi_bound); // RULE3 RULE14
  assign allow_d = hit_d && (cfg.nonsecure || lookup_secure); // RULE4 RULE5

  // Registered so the compare tree never sits on the consumer's path
  always_ff @(posedge clk) begin
    if (rst) begin
      hit_q <= 1'b0;
      allow_q <= 1'b0;
    end else begin
      hit_q <= hit_d;
      allow_q <= allow_d;
    end
  end

  assign hit = hit_q;
  assign allow = allow_q;
endmodule

//--- pcie_region_window_regs.sv
/*
  Region window register bank for the x8 and x16 root controllers, APB slave.
  Assumes an APB master on CLK; zero wait states; lookup inputs synchronous.
*/
// The APB register port is this design's own decision.
`timescale 1ns/100ps
`include "pcie_region_window_regs.svh"
module pcie_region_window_regs #(
  parameter int ADDR_W = 48
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [`APB_ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Window settings to the address decoders
  output logic [`LAST_MSB:0] X8_CFG_LAST_MB,
  output pcie_region_window_pkg::region_cfg_s X8_SECOND_WIN,
  output pcie_region_window_pkg::fine_cfg_s X8_SECOND_FINE,
  output pcie_region_window_pkg::region_cfg_s X16_FIRST_WIN,
  output pcie_region_window_pkg::region_cfg_s X16_LOW_IO_WIN,
  // Lookup port
  input wire logic [ADDR_W-1:0] LOOKUP_ADDR,
  input wire logic LOOKUP_SECURE,
  output logic [2:0] LOOKUP_HIT,
  output logic [2:0] LOOKUP_ALLOW
);
  // Register slots in address order
  localparam int IX_X8_CFG_LAST = 0;
  localparam int IX_X8_SEC_START = 1;
  localparam int IX_X8_SEC_LAST = 2;
  localparam int IX_X8_SEC_FINE = 3;
  localparam int IX_X16_FST_START = 4;
  localparam int IX_X16_FST_LAST = 5;
  localparam int IX_X16_LIO_START = 6;
  localparam int IX_X16_LIO_LAST = 7;
  localparam int NUM_WIN = 3;

  localparam logic [`APB_ADDR_W-1:0] OFS [`NUM_REGS] = '{
    `OFS_X8_CFG_LAST,
    `OFS_X8_SEC_START,
    `OFS_X8_SEC_LAST,
    `OFS_X8_SEC_FINE,
    `OFS_X16_FST_START,
    `OFS_X16_FST_LAST,
    `OFS_X16_LIO_START,
    `OFS_X16_LIO_LAST
  };

  // Writable bits of each slot; the rest reads zero
  localparam logic [31:0] MASK [`NUM_REGS] = '{
    `LAST_MASK,
    `START_MASK,
    `LAST_MASK,
    `FINE_MASK,
    `START_MASK,
    `LAST_MASK,
    `START_MASK,
    `LAST_MASK
  };

  logic [`NUM_REGS-1:0][31:0] regs_q;
  logic [`NUM_REGS-1:0][31:0] regs_d;
  logic [`NUM_REGS-1:0] sel;
  logic [31:0] byte_mask;
  logic [31:0] rd_mux;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic mapped;
  logic setup_phase;
  logic rd_setup;
  logic access_phase;
  logic wr_access;
  pcie_region_window_pkg::region_cfg_s win_cfg [NUM_WIN];
  pcie_region_window_pkg::fine_cfg_s win_fine [NUM_WIN];

  // Turn a start/end pair into one window description
  function automatic pcie_region_window_pkg::region_cfg_s unpack_win(
    input logic [31:0] start_reg,
    input logic [31:0] last_reg
  );
    pcie_region_window_pkg::region_cfg_s w;
    w.en = start_reg[`START_EN_BIT]; // RULE3
    w.nonsecure = start_reg[`NONSEC_BIT]; // RULE4 RULE5
    w.start = start_reg[`START_MSB:`START_LSB]; // RULE1
    w.last = last_reg[`LAST_MSB:0]; // RULE2
    return w;
  endfunction

  // APB phase decode
  assign setup_phase = PSEL && !PENABLE;
  assign rd_setup = setup_phase && !PWRITE;
  assign access_phase = PSEL && PENABLE;
  assign wr_access = access_phase && PWRITE;

  // Byte lanes expanded from the write strobes
  assign byte_mask = {{8{PSTRB[3]}}, {8{PSTRB[2]}}, {8{PSTRB[1]}}, {8{PSTRB[0]}}};

  // One slot per register, none of them optional
  genvar g;
  for (g = 0; g < `NUM_REGS; g++) begin : g_slot
    assign sel[g] = (PADDR == OFS[g]); // RULE9
    assign regs_d[g] = ((regs_q[g] & ~byte_mask) | (PWDATA & byte_mask)) & MASK[g]; // RULE6

    // Writes land at the access edge; masked bits can never become one
    always_ff @(posedge CLK) begin
      if (SYS_RST) begin
        regs_q[g] <= `REG_RESET; // RULE13
      end else if (wr_access && sel[g]) begin
        regs_q[g] <= regs_d[g];
      end
    end
  end

  assign mapped = |sel;

  // Read selection; an unmapped address returns zero
  always_comb begin
    rd_mux = '0;
    for (int i = 0; i < `NUM_REGS; i++) begin
      if (sel[i]) begin
        rd_mux = regs_q[i];
      end
    end
  end

  // Read data is captured in the setup cycle so PRDATA comes from a flop
  assign prdata_d = rd_setup ? rd_mux : prdata_q;

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      prdata_q <= '0;
    end else begin
      prdata_q <= prdata_d;
    end
  end

  // Zero wait states; only an unmapped address reports an error
  assign PRDATA = prdata_q;
  assign PREADY = 1'b1;
  assign PSLVERR = access_phase && !mapped;

  // Window settings straight from the register flops
  assign X8_CFG_LAST_MB = regs_q[IX_X8_CFG_LAST][`LAST_MSB:0]; // RULE2
  assign X8_SECOND_WIN = unpack_win(regs_q[IX_X8_SEC_START], regs_q[IX_X8_SEC_LAST]); // RULE11
  assign X8_SECOND_FINE.start =
    regs_q[IX_X8_SEC_FINE][`FINE_START_MSB:`FINE_START_LSB]; // RULE7
  assign X8_SECOND_FINE.last = regs_q[IX_X8_SEC_FINE][`FINE_LAST_MSB:0]; // RULE8
  assign X16_FIRST_WIN =
    unpack_win(regs_q[IX_X16_FST_START], regs_q[IX_X16_FST_LAST]); // RULE10
  assign X16_LOW_IO_WIN =
    unpack_win(regs_q[IX_X16_LIO_START], regs_q[IX_X16_LIO_LAST]); // RULE12

  // Windows without fine control span whole megabytes
  assign win_cfg[0] = X8_SECOND_WIN;
  assign win_fine[0] = X8_SECOND_FINE;
  assign win_cfg[1] = X16_FIRST_WIN;
  assign win_fine[1].start = `FINE_START_ZERO;
  assign win_fine[1].last = `FINE_LAST_FULL;
  assign win_cfg[2] = X16_LOW_IO_WIN;
  assign win_fine[2].start = `FINE_START_ZERO;
  assign win_fine[2].last = `FINE_LAST_FULL;

  // One matcher per full window; the config region has only its end here
  for (g = 0; g < NUM_WIN; g++) begin : g_match
    region_window_match #(
      .ADDR_W(ADDR_W)
    ) u_match (
      .clk(CLK),
      .rst(SYS_RST),
      .cfg(win_cfg[g]),
      .fine(win_fine[g]),
      .lookup_addr(LOOKUP_ADDR),
      .lookup_secure(LOOKUP_SECURE),
      .hit(LOOKUP_HIT[g]),
      .allow(LOOKUP_ALLOW[g])
    ); // RULE14
  end

  // Checks below share one clock and reset
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);

  logic full_wr;
  assign full_wr = wr_access && (PSTRB == 4'hF);

  // Start field lands in bits 28:1
  start_field_wr_a: assert property ( // RULE1
    full_wr && sel[IX_X16_FST_START] |=> X16_FIRST_WIN.start == $past(PWDATA[28:1])
  ) else $error("start field not stored from write data bits 28:1");

  // End field lands in bits 27:0
  last_field_wr_a: assert property ( // RULE2
    full_wr && sel[IX_X16_LIO_LAST] |=> X16_LOW_IO_WIN.last == $past(PWDATA[27:0])
  ) else $error("end field not stored from write data bits 27:0");

  // A disabled window never reports a hit
  enable_gates_hit_a: assert property ( // RULE3
    !X16_LOW_IO_WIN.en |=> !LOOKUP_HIT[2]
  ) else $error("hit reported by a disabled window");

  // Non-secure window passes whatever it hits
  nonsecure_pass_a: assert property ( // RULE4
    X16_FIRST_WIN.nonsecure |=> LOOKUP_ALLOW[1] == LOOKUP_HIT[1]
  ) else $error("non-secure window refused a hit");

  // Secure window refuses non-secure lookups
  secure_only_a: assert property ( // RULE5
    !X8_SECOND_WIN.nonsecure && !LOOKUP_SECURE |=> !LOOKUP_ALLOW[0]
  ) else $error("secure window let a non-secure access pass");

  // Reserved bits of a start register read zero
  raz_start_a: assert property ( // RULE6
    rd_setup && sel[IX_X8_SEC_START] |=> PRDATA[31:30] == 2'h0
  ) else $error("start register reserved bits read non-zero");

  // Reserved bits of an end register read zero
  raz_last_a: assert property ( // RULE6
    rd_setup && sel[IX_X8_CFG_LAST] |=> PRDATA[31:28] == 4'h0
  ) else $error("end register reserved bits read non-zero");

  // Reserved bits of the fine control read zero
  raz_fine_a: assert property ( // RULE6
    rd_setup && sel[IX_X8_SEC_FINE] |=> PRDATA[31:10] == 22'h0
  ) else $error("fine control reserved bits read non-zero");

  // Fine start in bits 9:5
  fine_start_wr_a: assert property ( // RULE7
    full_wr && sel[IX_X8_SEC_FINE] |=> X8_SECOND_FINE.start == $past(PWDATA[9:5])
  ) else $error("fine start not stored from bits 9:5");

  // Fine end in bits 4:0
  fine_last_wr_a: assert property ( // RULE8
    full_wr && sel[IX_X8_SEC_FINE] |=> X8_SECOND_FINE.last == $past(PWDATA[4:0])
  ) else $error("fine end not stored from bits 4:0");

  // Every printed offset answers without error
  mapped_no_err_a: assert property ( // RULE9
    access_phase && mapped |-> !PSLVERR ##1 1'b1
  ) else $error("error answer on a mapped register");

  // Writes to the x8 window leave the x16 window alone
  x16_separate_a: assert property ( // RULE10
    wr_access && sel[IX_X8_SEC_START] |=> $stable(X16_FIRST_WIN)
  ) else $error("x8 write disturbed the x16 first window");

  // Low I/O window start write is seen two edges later by the matcher
  lio_enable_a: assert property ( // RULE12
    full_wr && sel[IX_X16_LIO_START] && !PWDATA[0] |=> ##1 !LOOKUP_HIT[2]
  ) else $error("low I/O window hit after being disabled");

  // Reset clears every slot, the lookup hits and the read data
  reset_zero_a: assert property ( // RULE13
    disable iff (1'b0) SYS_RST |=> (regs_q == '0) && (LOOKUP_HIT == 3'h0) && (PRDATA == '0)
  ) else $error("state not zero after reset");

  // Inclusive bounds on a whole-megabyte window
  range_hit_a: assert property ( // RULE14
    X16_FIRST_WIN.en && LOOKUP_ADDR[ADDR_W-1 -: 28] >= X16_FIRST_WIN.start
    && LOOKUP_ADDR[ADDR_W-1 -: 28] <= X16_FIRST_WIN.last |=> LOOKUP_HIT[1]
  ) else $error("in-range address missed by the x16 first window");

  // Start field of the other two windows lands in bits 28:1
  x8_start_wr_a: assert property ( // RULE1
    full_wr && sel[IX_X8_SEC_START] |=> X8_SECOND_WIN.start == $past(PWDATA[28:1])
  ) else $error("x8 second window start not stored from bits 28:1");

  // Low I/O start field
  lio_start_wr_a: assert property ( // RULE1
    full_wr && sel[IX_X16_LIO_START] |=> X16_LOW_IO_WIN.start == $past(PWDATA[28:1])
  ) else $error("low I/O window start not stored from bits 28:1");

  // End field of the x8 second window
  x8_last_wr_a: assert property ( // RULE2
    full_wr && sel[IX_X8_SEC_LAST] |=> X8_SECOND_WIN.last == $past(PWDATA[27:0])
  ) else $error("x8 second window end not stored from bits 27:0");

  // Config region end goes straight out
  cfg_last_wr_a: assert property ( // RULE2
    full_wr && sel[IX_X8_CFG_LAST] |=> X8_CFG_LAST_MB == $past(PWDATA[27:0])
  ) else $error("config region end not stored from bits 27:0");

  // End field of the x16 first window
  fst_last_wr_a: assert property ( // RULE2
    full_wr && sel[IX_X16_FST_LAST] |=> X16_FIRST_WIN.last == $past(PWDATA[27:0])
  ) else $error("x16 first window end not stored from bits 27:0");

  // Enable flag follows bit 0
  enable_bit_wr_a: assert property ( // RULE3
    full_wr && sel[IX_X16_FST_START] |=> X16_FIRST_WIN.en == $past(PWDATA[0])
  ) else $error("enable flag not stored from bit 0");

  // Security flag follows bit 29
  nonsec_bit_wr_a: assert property ( // RULE4
    full_wr && sel[IX_X8_SEC_START] |=> X8_SECOND_WIN.nonsecure == $past(PWDATA[29])
  ) else $error("security flag not stored from bit 29");

  // A lane left out of the strobes keeps the enable flag
  strobe_keep_a: assert property ( // RULE3
    wr_access && sel[IX_X16_FST_START] && !PSTRB[0] |=> X16_FIRST_WIN.en == $past(X16_FIRST_WIN.en)
  ) else $error("enable flag changed by a write without its byte lane");

  // Secure low I/O window refuses non-secure lookups
  lio_secure_only_a: assert property ( // RULE5
    !X16_LOW_IO_WIN.nonsecure && !LOOKUP_SECURE |=> !LOOKUP_ALLOW[2]
  ) else $error("secure low I/O window let a non-secure access pass");

  // A write outside the bank changes no slot
  unmapped_wr_a: assert property ( // RULE9
    wr_access && !mapped |=> $stable(regs_q)
  ) else $error("write to an unmapped address changed a register");

  // Read data of an end register is what the decoders see, upper bits zero
  read_back_a: assert property ( // RULE2
    rd_setup && sel[IX_X16_LIO_LAST] |=> PRDATA == {4'h0, $past(X16_LOW_IO_WIN.last)}
  ) else $error("end register read differs from the stored end");

  // Both x8 bounds in 32 KB steps; a swapped pair must never hit
  logic [32:0] x8_lo;
  logic [32:0] x8_hi;
  logic [32:0] x8_probe;
  assign x8_lo = {X8_SECOND_WIN.start, X8_SECOND_FINE.start};
  assign x8_hi = {X8_SECOND_WIN.last, X8_SECOND_FINE.last};
  assign x8_probe = LOOKUP_ADDR[ADDR_W-1 -: 33];

  // Fine start is the first hitting step
  fine_lo_hit_a: assert property ( // RULE7
    X8_SECOND_WIN.en && (x8_probe == x8_lo) && (x8_lo <= x8_hi) |=> LOOKUP_HIT[0]
  ) else $error("x8 second window missed its fine start");

  // Fine end is the last hitting step
  fine_hi_hit_a: assert property ( // RULE8
    X8_SECOND_WIN.en && (x8_probe == x8_hi) && (x8_lo <= x8_hi) |=> LOOKUP_HIT[0]
  ) else $error("x8 second window missed its fine end");

  // Writes to the x16 window leave the x8 window alone
  x8_separate_a: assert property ( // RULE11
    wr_access && sel[IX_X16_FST_START] |=> $stable(X8_SECOND_WIN) && $stable(X8_SECOND_FINE)
  ) else $error("x16 write disturbed the x8 second window");

  // Inclusive bounds on the low I/O window
  lio_range_a: assert property ( // RULE12
    X16_LOW_IO_WIN.en && LOOKUP_ADDR[ADDR_W-1 -: 28] >= X16_LOW_IO_WIN.start
    && LOOKUP_ADDR[ADDR_W-1 -: 28] <= X16_LOW_IO_WIN.last |=> LOOKUP_HIT[2]
  ) else $error("in-range address missed by the low I/O window");

  // Main scenarios
  secure_deny_c: cover property (LOOKUP_HIT[0] && !LOOKUP_ALLOW[0]);
  nonsecure_pass_c: cover property (LOOKUP_HIT[2] && LOOKUP_ALLOW[2] && $past(!LOOKUP_SECURE));
  fine_write_c: cover property (full_wr && sel[IX_X8_SEC_FINE]);
  unmapped_err_c: cover property (PSLVERR);
  strobe_part_c: cover property (wr_access && mapped && (PSTRB != 4'hF));
endmodule

//--- pcie_region_window_regs_test.sv
/*
  Self-checking bench for the region window bank: APB reads and writes, window lookups.
  Assumes the bank, its package and its header are compiled first; one 50 MHz clock.
*/
`timescale 1ns/100ps
`include "pcie_region_window_regs.svh"
module pcie_region_window_regs_test;
  // Compare and count; case inequality so an unknown never matches
  `define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic lsec = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'h0;
  logic [47:0] laddr = 48'h0000_0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [27:0] cfg_last;
  pcie_region_window_pkg::region_cfg_s w8;
  pcie_region_window_pkg::region_cfg_s w16a;
  pcie_region_window_pkg::region_cfg_s w16b;
  pcie_region_window_pkg::fine_cfg_s f8;
  logic [2:0] hit;
  logic [2:0] allow;
  int num_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [31:0] rdv;
  logic err;
  logic [11:0] ofs [8] = '{`OFS_X8_CFG_LAST, `OFS_X8_SEC_START, `OFS_X8_SEC_LAST,
    `OFS_X8_SEC_FINE, `OFS_X16_FST_START, `OFS_X16_FST_LAST, `OFS_X16_LIO_START,
    `OFS_X16_LIO_LAST};
  logic [31:0] msk [8] = '{`LAST_MASK, `START_MASK, `LAST_MASK, `FINE_MASK, `START_MASK,
    `LAST_MASK, `START_MASK, `LAST_MASK};

  pcie_region_window_regs i_dut (
    .CLK(clk), .SYS_RST(sys_rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .X8_CFG_LAST_MB(cfg_last), .X8_SECOND_WIN(w8), .X8_SECOND_FINE(f8),
    .X16_FIRST_WIN(w16a), .X16_LOW_IO_WIN(w16b), .LOOKUP_ADDR(laddr),
    .LOOKUP_SECURE(lsec), .LOOKUP_HIT(hit), .LOOKUP_ALLOW(allow)
  );

  // Clock and hang guard; the ceiling is some twenty times the expected run of about 150 cycles
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      print_verdict();
    end
  end

  // One APB transfer; request held until pready is seen at a rising edge
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
    output logic [31:0] q, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // Only the bench timeout ends a wait for the slave
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 4'hF, rdv, err);
  endtask

  // Start word: reserved, non-secure, megabyte, enable
  function automatic logic [31:0] mk(input logic en, input logic ns, input logic [27:0] mb);
    return {2'b00, ns, mb, en};
  endfunction

  // Lookup: registered, so the answer is read one edge after the inputs are taken
  task lk(input logic [47:0] a, input logic s, input logic [2:0] eh, input logic [2:0] ea);
    @(posedge clk);
    laddr <= a;
    lsec <= s;
    @(posedge clk);
    @(negedge clk);
    `CHK("hit", eh, hit)
    `CHK("allow", ea, allow)
  endtask

  task print_verdict;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      xfer(1'b0, ofs[i], 32'h0000_0000, 4'h0, rdv, err);
      `CHK("reset value", 32'h0000_0000, rdv)
      `CHK("slverr", 1'b0, err)
    end
    $display("test reset values done");
    // Distinct words first, all read back afterwards, to catch aliasing
    for (int i = 0; i < 8; i++) wr(ofs[i], 32'hFFFF_FFF8 | i);
    for (int i = 0; i < 8; i++) begin
      xfer(1'b0, ofs[i], 32'h0000_0000, 4'h0, rdv, err);
      `CHK("readback", (32'hFFFF_FFF8 | i) & msk[i], rdv)
    end
    xfer(1'b1, `OFS_X16_FST_START, 32'h0000_0000, 4'h2, rdv, err);
    xfer(1'b0, `OFS_X16_FST_START, 32'h0000_0000, 4'h0, rdv, err);
    `CHK("strobe", 32'hFFFF_FFFC & `START_MASK & 32'hFFFF_00FF, rdv)
    xfer(1'b1, 12'h220, 32'hFFFF_FFFF, 4'hF, rdv, err);
    `CHK("unmapped wr err", 1'b1, err)
    xfer(1'b0, 12'h220, 32'h0000_0000, 4'h0, rdv, err);
    `CHK("unmapped rd", 32'h0000_0000, rdv)
    $display("test access done");
    // Program all windows and check what the decoders see
    wr(`OFS_X8_CFG_LAST, 32'hFABC_DEF1);
    wr(`OFS_X16_FST_START, mk(1'b1, 1'b0, 28'h000_0010));
    wr(`OFS_X16_FST_LAST, 32'h0000_0020);
    wr(`OFS_X16_LIO_START, mk(1'b1, 1'b1, 28'h000_0040));
    wr(`OFS_X16_LIO_LAST, 32'h0000_0040);
    wr(`OFS_X8_SEC_START, mk(1'b1, 1'b0, 28'h000_0005));
    wr(`OFS_X8_SEC_LAST, 32'h0000_0005);
    wr(`OFS_X8_SEC_FINE, {22'h00_0000, 5'h03, 5'h07});
    // The last write lands at the edge just passed; look once it has settled
    @(negedge clk);
    `CHK("cfg last", 28'hABC_DEF1, cfg_last)
    `CHK("x16 first", {1'b1, 1'b0, 28'h000_0010, 28'h000_0020}, w16a)
    `CHK("x16 low io", {1'b1, 1'b1, 28'h000_0040, 28'h000_0040}, w16b)
    `CHK("x8 second", {1'b1, 1'b0, 28'h000_0005, 28'h000_0005}, w8)
    `CHK("x8 fine", {5'h03, 5'h07}, f8)
    $display("test window outputs done");
    lk({28'h000_0010, 20'h0_0000}, 1'b1, 3'b010, 3'b010);
    lk({28'h000_0020, 20'hF_FFFF}, 1'b0, 3'b010, 3'b000);
    lk({28'h000_000F, 20'hF_FFFF}, 1'b1, 3'b000, 3'b000);
    lk({28'h000_0021, 20'h0_0000}, 1'b1, 3'b000, 3'b000);
    lk({28'h000_0040, 20'h0_0008}, 1'b0, 3'b100, 3'b100);
    lk({28'h000_0005, 5'h03, 15'h0000}, 1'b1, 3'b001, 3'b001);
    lk({28'h000_0005, 5'h02, 15'h7FFF}, 1'b1, 3'b000, 3'b000);
    lk({28'h000_0005, 5'h07, 15'h7FFF}, 1'b1, 3'b001, 3'b001);
    lk({28'h000_0005, 5'h08, 15'h0000}, 1'b1, 3'b000, 3'b000);
    wr(`OFS_X16_FST_START, mk(1'b0, 1'b0, 28'h000_0010));
    lk({28'h000_0010, 20'h0_0000}, 1'b1, 3'b000, 3'b000);
    wr(`OFS_X16_FST_START, mk(1'b1, 1'b1, 28'h000_0010));
    lk({28'h000_0018, 20'h0_0000}, 1'b0, 3'b010, 3'b010);
    $display("test lookup done");
    // Reset in mid-run clears everything again
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    xfer(1'b0, `OFS_X16_FST_START, 32'h0000_0000, 4'h0, rdv, err);
    `CHK("second reset", 32'h0000_0000, rdv)
    lk({28'h000_0040, 20'h0_0008}, 1'b1, 3'b000, 3'b000);
    $display("test second reset done");
    print_verdict();
  end
endmodule
